//--- verilog/ebi_bus.sv
`timescale 1ns/1ns
// Behaviour
// - muxed AD low address/data, separate high address
// - fetch, constant read, data read, data write
// - fetch bytes to queue, reads to core
// - cycle length independent of address
// - code and data read lengths set separately
// - code fetch may abort when unneeded
// - queue stall stretches code reads only
// - writes go straight out, no caching
// - bit7 prefetch enable, bit6 branch cache enable
// - both enables set after reset
// - write_wait 5:4 gives 4..7 periods
// - read_wait 3:2 gives 4..7 periods
// - bus_control resets to eb
module ebi_bus
  import ebi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm register slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // core request side
  input  wire logic        core_req,
  input  wire logic [1:0]  core_type,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  output logic             core_ready,
  output logic             read_valid,
  output logic [7:0]       read_data,
  output logic             write_done,
  // prefetch queue and branch cache side
  input  wire logic        fetch_abort,
  input  wire logic        prefetch_queue_stall,
  output logic             fetch_valid,
  output logic [7:0]       fetch_data,
  output logic             prefetch_enable,
  output logic             branch_cache_enable,
  // external bus pins
  input  wire logic [7:0]  ad_i,
  output logic [7:0]       ad_o,
  output logic             ad_oe,
  output logic [7:0]       a_hi,
  output logic             ale,
  output logic             code_read_strobe_n,
  output logic             rd_n,
  output logic             wr_n
);

  logic [7:0]  ctl_r;
  logic        ack_r;
  logic [9:0]  idx;
  logic        wr_ctl;
  ebi_xfer_t   type_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  logic [2:0]  len_r;
  logic [2:0]  sel_len;
  logic        take;
  logic        busy;
  logic [2:0]  phase;
  logic        last;
  logic        is_code;
  logic        in_strobe;
  logic        hold;
  logic        abort;
  logic        stalled_r;

  // ---------------- register slave ----------------
  assign idx             = avs_address[EBI_IDX_MSB:EBI_IDX_LSB];
  // one wait state: the access completes on the second edge
  assign avs_waitrequest = ~ack_r;
  assign wr_ctl          = avs_write & ack_r & (idx == EBI_IDX_CTL) & avs_byteenable[0];

  // acknowledge toggles so a held request is served exactly once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // bus_control; all fields are live, a change applies from the next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= EBI_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= avs_writedata[7:0];
    end
  end

  assign prefetch_enable     = ctl_r[EBI_PREFETCH_BIT];
  assign branch_cache_enable = ctl_r[EBI_BRANCH_BIT];

  // read data is set up while waitrequest is still high; unmapped reads zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_r) begin
      if (idx == EBI_IDX_CTL) begin
        avs_readdata <= {24'h0, ctl_r};
      end else if (idx == EBI_IDX_STAT) begin
        avs_readdata <= {25'h0, len_r, stalled_r, type_r, busy};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  // ---------------- transfer control ----------------
  // length picked per type only, the address never enters it
  always_comb begin
    unique case (ebi_xfer_t'(core_type))
      EBI_FETCH, EBI_CONST: begin
        sel_len = 3'(EBI_CYC_BASE + {1'b0, ctl_r[EBI_CODE_WAIT_LSB +: 2]});
      end
      EBI_DREAD:  sel_len = 3'(EBI_CYC_BASE + {1'b0, ctl_r[EBI_READ_WAIT_LSB +: 2]});
      EBI_DWRITE: sel_len = 3'(EBI_CYC_BASE + {1'b0, ctl_r[EBI_WRITE_WAIT_LSB +: 2]});
    endcase
  end

  assign core_ready = ~busy;
  assign take       = core_req & ~busy;

  // request latch, held steady for the whole bus cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      type_r  <= EBI_FETCH;
      addr_r  <= 16'h0;
      wdata_r <= 8'h0;
      len_r   <= EBI_CYC_BASE;
    end else if (take) begin
      type_r  <= ebi_xfer_t'(core_type);
      addr_r  <= core_addr;
      wdata_r <= core_wdata;
      len_r   <= sel_len;
    end
  end

  assign is_code   = (type_r == EBI_FETCH) | (type_r == EBI_CONST);
  assign in_strobe = busy & (phase >= EBI_STB_PHASE);
  // a queue stall stretches only code reads, and only once the strobe is low
  assign hold      = in_strobe & is_code & prefetch_queue_stall;
  // only instruction fetches may be dropped; constant reads always finish
  assign abort     = busy & (type_r == EBI_FETCH) & fetch_abort;

  ebi_cycle_timer u_timer (
    .clk    (clk),
    .rstn   (rstn),
    .start  (take),
    .len    (len_r),
    .hold   (hold),
    .abort  (abort),
    .active (busy),
    .phase  (phase),
    .last   (last)
  );

  // stall or abort seen in this transfer, shown in status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stalled_r <= 1'b0;
    end else if (take) begin
      stalled_r <= 1'b0;
    end else if (hold || abort) begin
      stalled_r <= 1'b1;
    end
  end

  // ---------------- pins ----------------
  // address phase on ad for periods 0 and 1, latched by the far side on ale
  assign ale                = busy & (phase == EBI_ALE_PHASE);
  assign a_hi               = addr_r[15:8];
  assign ad_o               = in_strobe ? wdata_r : addr_r[7:0];
  assign ad_oe              = busy & (~in_strobe | (type_r == EBI_DWRITE));
  assign code_read_strobe_n = ~(in_strobe & is_code);
  assign rd_n               = ~(in_strobe & (type_r == EBI_DREAD));
  assign wr_n               = ~(in_strobe & (type_r == EBI_DWRITE));

  // ---------------- completion ----------------
  // data sampled in the last strobe period and routed by type
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_valid <= 1'b0;
      read_valid  <= 1'b0;
      write_done  <= 1'b0;
    end else begin
      fetch_valid <= last & (type_r == EBI_FETCH);
      read_valid  <= last & ((type_r == EBI_CONST) | (type_r == EBI_DREAD));
      write_done  <= last & (type_r == EBI_DWRITE);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_data <= 8'h0;
      read_data  <= 8'h0;
    end else if (last && type_r == EBI_FETCH) begin
      fetch_data <= ad_i;
    end else if (last && type_r != EBI_DWRITE) begin
      read_data  <= ad_i;
    end
  end

  // ---------------- checks ----------------
  logic [2:0] low_cnt_r;
  logic       any_low;

  assign any_low = ~code_read_strobe_n | ~rd_n | ~wr_n;

  // strobe-low length counter, only read by the checks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_r <= 3'h0;
    end else if (any_low) begin
      low_cnt_r <= 3'(low_cnt_r + 3'h1);
    end else begin
      low_cnt_r <= 3'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_ale_first;
    take |=> ale && ad_oe && ad_o == addr_r[7:0] ##1 !ale && ad_oe && !any_low;
  endproperty
  a_ale_first: assert property (p_ale_first)
    else $error("ale not first in bus cycle");

  property p_hi_addr;
    take |=> a_hi == $past(core_addr[15:8]);
  endproperty
  a_hi_addr: assert property (p_hi_addr)
    else $error("high address not driven");

  property p_one_strobe;
    $onehot0({~code_read_strobe_n, ~rd_n, ~wr_n}) && !(ale && any_low);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("strobes overlap");

  property p_rd_len;
    $rose(rd_n) |-> low_cnt_r == 3'(len_r - EBI_STB_PHASE);
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("data read length wrong");

  property p_wr_len;
    $rose(wr_n) |-> low_cnt_r == 3'(len_r - EBI_STB_PHASE);
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write length wrong");

  property p_len_sel;
    take && ebi_xfer_t'(core_type) == EBI_DREAD |=>
      len_r == 3'(EBI_CYC_BASE + {1'b0, $past(ctl_r[EBI_READ_WAIT_LSB +: 2])});
  endproperty
  a_len_sel: assert property (p_len_sel)
    else $error("read length not from read_wait");

  property p_code_len;
    take && ebi_xfer_t'(core_type) != EBI_DREAD && ebi_xfer_t'(core_type) != EBI_DWRITE |=>
      len_r == 3'(EBI_CYC_BASE + {1'b0, $past(ctl_r[EBI_CODE_WAIT_LSB +: 2])});
  endproperty
  a_code_len: assert property (p_code_len)
    else $error("code length not from code_cycle_wait");

  property p_wr_data;
    !wr_n |-> ad_oe && ad_o == wdata_r;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not driven");

  property p_abort;
    abort |=> code_read_strobe_n && !busy ##1 !fetch_valid;
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted fetch not dropped");

  property p_route;
    fetch_valid |-> !read_valid && $past(type_r, 2) == EBI_FETCH;
  endproperty
  a_route: assert property (p_route)
    else $error("fetch byte misrouted");

  property p_cfg;
    wr_ctl |=> prefetch_enable == $past(avs_writedata[7])
      && branch_cache_enable == $past(avs_writedata[6]);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("enable bits not updated");

  property p_pulse_one;
    $onehot0({fetch_valid, read_valid, write_done});
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("completion pulses overlap");

  property p_fetch_byte;
    fetch_valid |-> fetch_data == $past(ad_i);
  endproperty
  a_fetch_byte: assert property (p_fetch_byte)
    else $error("fetch byte not taken from bus");

  property p_read_byte;
    read_valid |-> read_data == $past(ad_i) && $stable(fetch_data);
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("read byte not routed to core");

  property p_wr_no_cache;
    write_done |-> $stable(fetch_data) && $stable(read_data);
  endproperty
  a_wr_no_cache: assert property (p_wr_no_cache)
    else $error("write disturbed read path");

  // a stall that meets an abort may legally end the cycle, so it is left out
  property p_stretch;
    hold && !abort |=> busy && $stable(phase);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stall did not freeze code cycle");

  property p_ale_once;
    ale |=> !ale;
  endproperty
  a_ale_once: assert property (p_ale_once)
    else $error("ale longer than one period");

  property p_avs_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_avs_wait: assert property (p_avs_wait)
    else $error("register access not answered");

  c_fetch:   cover property (take && ebi_xfer_t'(core_type) == EBI_FETCH ##[4:20] fetch_valid);
  c_stall:   cover property (hold ##1 hold);
  c_abort:   cover property (abort);
  c_write:   cover property ($rose(wr_n) && low_cnt_r == 3'h2);
  c_dread:   cover property ($rose(rd_n) && read_valid);

endmodule : ebi_bus

//--- verilog/ebi_pkg.sv
package ebi_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] EBI_IDX_CTL    = 10'h09d;
  localparam logic [9:0] EBI_IDX_STAT   = 10'h09e;
  localparam int         EBI_IDX_LSB    = 2;
  localparam int         EBI_IDX_MSB    = 11;

  // bus_control layout and reset value
  localparam logic [7:0] EBI_CTL_RESET  = 8'heb;
  localparam int         EBI_PREFETCH_BIT   = 7;
  localparam int         EBI_BRANCH_BIT     = 6;
  localparam int         EBI_WRITE_WAIT_LSB = 4;
  localparam int         EBI_READ_WAIT_LSB  = 2;
  localparam int         EBI_CODE_WAIT_LSB  = 0;

  // status layout
  localparam int         EBI_ST_BUSY    = 0;
  localparam int         EBI_ST_TYPE    = 1;
  localparam int         EBI_ST_STALL   = 3;
  localparam int         EBI_ST_LEN     = 4;

  // bus cycle timing in core clock periods
  localparam logic [2:0] EBI_CYC_BASE   = 3'h4;
  localparam logic [2:0] EBI_ALE_PHASE  = 3'h0;
  localparam logic [2:0] EBI_STB_PHASE  = 3'h2;

  typedef enum logic [1:0] {
    EBI_FETCH,
    EBI_CONST,
    EBI_DREAD,
    EBI_DWRITE
  } ebi_xfer_t;

endpackage : ebi_pkg

//--- verilog/ebi_cycle_timer.sv
`timescale 1ns/1ns
module ebi_cycle_timer
  import ebi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [2:0] len,
  input  wire logic       hold,
  input  wire logic       abort,
  output logic            active,
  output logic [2:0]      phase,
  output logic            last
);

  logic [2:0] end_phase;

  assign end_phase = 3'(len - 3'h1);
  // final period of the cycle; a held or aborted period never completes
  assign last      = active & ~hold & ~abort & (phase == end_phase);

  // phase counter; hold freezes it so the strobe stretches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
      phase  <= EBI_ALE_PHASE;
    end else if (start) begin
      active <= 1'b1;
      phase  <= EBI_ALE_PHASE;
    end else if (active && abort) begin
      active <= 1'b0;
    end else if (active && !hold) begin
      if (phase == end_phase) begin
        active <= 1'b0;
      end else begin
        phase <= 3'(phase + 3'h1);
      end
    end
  end

endmodule : ebi_cycle_timer

//--- bench/ebi_mem_model.sv
`timescale 1ns/1ns
// external memory on the muxed bus; it drives only while a read strobe is low
module ebi_mem_model
  import ebi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  ad_o,
  input  wire logic        ad_oe,
  input  wire logic [7:0]  a_hi,
  input  wire logic        ale,
  input  wire logic        code_read_strobe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic [7:0]       ad_i,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_byte
);
  logic [7:0] lo_r;
  logic [7:0] last_r = 8'h00;
  logic       sel;
  logic [7:0] val;

  // code and data spaces hold different patterns, so a wrong strobe shows
  assign sel  = !code_read_strobe_n || !rd_n;
  assign val  = a_hi ^ lo_r ^ (!code_read_strobe_n ? 8'hc3 : 8'h5a);
  // a released bus shows the inverse of the last byte, never a stale copy
  assign ad_i = sel ? val : ~last_r;

  // low address is taken only while the latch strobe is high
  always_ff @(posedge clk) begin
    if (ale && ad_oe) lo_r <= ad_o;
    if (sel) last_r <= val;
    if (!wr_n && ad_oe) begin
      wr_addr <= {a_hi, lo_r};
      wr_byte <= ad_o;
    end
  end
endmodule : ebi_mem_model

//--- bench/test_ebi_bus.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module test_ebi_bus
  import ebi_pkg::*;
;
  localparam logic [11:0] CTL_A = {EBI_IDX_CTL, 2'b00};
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        core_req, core_ready, read_valid, write_done, fetch_abort, prefetch_queue_stall;
  logic [1:0]  core_type;
  logic [15:0] core_addr, wr_addr;
  logic [7:0]  core_wdata, read_data, fetch_data, ad_i, ad_o, a_hi, wr_byte;
  logic        fetch_valid, prefetch_enable, branch_cache_enable, ad_oe, ale;
  logic        code_read_strobe_n, rd_n, wr_n;
  int          err_total, compares, cyc_cnt;

  ebi_bus DUT (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_req, .core_type,
    .core_addr, .core_wdata, .core_ready, .read_valid, .read_data, .write_done,
    .fetch_abort, .prefetch_queue_stall, .fetch_valid, .fetch_data, .prefetch_enable,
    .branch_cache_enable, .ad_i, .ad_o, .ad_oe, .a_hi, .ale, .code_read_strobe_n,
    .rd_n, .wr_n);
  ebi_mem_model u_mem (.clk, .ad_o, .ad_oe, .a_hi, .ale, .code_read_strobe_n,
    .rd_n, .wr_n, .ad_i, .wr_addr, .wr_byte);

  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // expected cycle length, strobe pattern, pulse and read byte
  function automatic int len(input logic [1:0] t, input logic [7:0] v);
    return 4 + (t < 2 ? v[1:0] : (t == 2 ? v[3:2] : v[5:4]));
  endfunction : len
  function automatic logic [3:0] strb(input logic [1:0] t);
    return t < 2 ? 4'b0110 : (t == 2 ? 4'b1010 : 4'b1100);
  endfunction : strb
  function automatic logic [2:0] pul(input logic [1:0] t);
    return t == 0 ? 3'b100 : (t < 3 ? 3'b010 : 3'b001);
  endfunction : pul
  function automatic logic [7:0] expb(input logic [1:0] t, input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ (t < 2 ? 8'hc3 : 8'h5a);
  endfunction : expb

  // one register access; held until waitrequest is seen low
  task automatic avs(input bit wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    // waitrequest and read data are both taken at the rising edge of the answer
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : avs

  // one bus cycle; n is the cycle of the completion pulse, 0 if none came
  task automatic xfer(input logic [1:0] t, input logic [15:0] a, input logic [7:0] d,
                      input int st, input bit ab, output int n);
    @(posedge clk);
    core_type  <= t;
    core_addr  <= a;
    core_wdata <= d;
    core_req   <= 1'b1;
    // released at the rising edge that sees core_ready high, the taking edge
    do @(posedge clk); while (core_ready !== 1'b1);
    core_req <= 1'b0;
    n = 0;
    for (int i = 1; i < 40 && n == 0; i++) begin
      @(negedge clk);
      if (i == 1) begin
        `CHK("ale", 1'b1, ale)
        `CHK("ad_lo", {1'b1, a[7:0]}, {ad_oe, ad_o})
        `CHK("a_hi", a[15:8], a_hi)
      end
      if (i == 3) begin
        `CHK("strobes", strb(t), {code_read_strobe_n, rd_n, wr_n, ale})
        if (t == 3) `CHK("ad_wr", {1'b1, d}, {ad_oe, ad_o})
      end
      if ({fetch_valid, read_valid, write_done} !== 3'b000) begin
        n = i;
        `CHK("pulse", pul(t), {fetch_valid, read_valid, write_done})
        if (t < 3) `CHK("rdata", expb(t, a), t == 0 ? fetch_data : read_data)
        else `CHK("wr", {a, d}, {wr_addr, wr_byte})
      end
      @(posedge clk);
      prefetch_queue_stall <= i >= 2 && i < 2 + st;
      fetch_abort <= ab && i == 3;
    end
  endtask : xfer

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // main sequence: reset values, random configurations, stall, abort
  initial begin
    int          n;
    logic [31:0] q;
    logic [7:0]  v;
    {rstn, avs_read, avs_write, core_req, fetch_abort, prefetch_queue_stall} = '0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {core_type, core_addr, core_wdata} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    void'($urandom(32'h562d419b));
    `CHK("en_rst", 2'b11, {prefetch_enable, branch_cache_enable})
    avs(0, CTL_A, 32'h0, 4'hf, q);
    `CHK("ctl_rst", 32'h000000eb, q)
    avs(0, 12'hffc, 32'h0, 4'hf, q);
    `CHK("unmapped", 32'h0, q)
    $display("reset values done");
    v = 8'heb;
    for (int k = 0; k < 12; k++) begin
      if (k == 1) v = 8'h30;
      else if (k > 1) v = 8'($urandom);
      avs(1, CTL_A, {24'h0, v}, 4'h1, q);
      avs(0, CTL_A, 32'h0, 4'hf, q);
      `CHK("ctl", {24'h0, v}, q)
      `CHK("en", v[7:6], {prefetch_enable, branch_cache_enable})
      for (int j = 0; j < 4; j++) begin
        xfer(2'(j), 16'($urandom), 8'($urandom), 0, 0, n);
        `CHK("len", len(2'(j), v) + 1, n)
      end
      $display("config %0h done", v);
    end
    avs(1, CTL_A, 32'h0, 4'he, q);
    avs(0, CTL_A, 32'h0, 4'hf, q);
    `CHK("ctl_be", {24'h0, v}, q)
    xfer(2'd1, 16'h1234, 8'h00, 2, 0, n);
    `CHK("stall_code", len(2'd1, v) + 3, n)
    xfer(2'd2, 16'h1234, 8'h00, 2, 0, n);
    `CHK("stall_data", len(2'd2, v) + 1, n)
    $display("stall done");
    xfer(2'd0, 16'h4321, 8'h00, 0, 1, n);
    `CHK("abort", 0, n)
    `CHK("abort_idle", 1'b1, code_read_strobe_n)
    avs(0, {EBI_IDX_STAT, 2'b00}, 32'h0, 4'hf, q);
    `CHK("status", {25'h0, 3'(len(2'd0, v)), 4'b1000}, q)
    $display("abort done");
    give_verdict();
  end
endmodule : test_ebi_bus
